/* File: cmp_pkg.sv */
// constants, register map and field layout of the comparator control block
// How it works
// - each comparator enable powers it; toggling it leaves other fields alone.
// - pin enable routes the result to the comparator pin, else pin undriven.
// - invert flips the result before the readable bit and the pin.
// - invert also feeds the edge detector, so interrupts fire on the other edge.
// - read-only result bit in each control register shows the current result.
// - edge field: 00 off, 01 rising, 10 falling, 11 both.
// - plus select picks ladder reference when set, else input pin a.
// - minus select: 00 pin b, 01 pin c, 10 pin d, 11 fixed reference.
// - idle halt stops all comparators in idle mode when set.
// - status mirrors results: comparator 1 bit 0, 2 bit 1, 3 bit 2.
// - unimplemented bits ignore writes and read as zero.
// - ladder enable powers the ladder and leaves other ladder fields alone.
// - ladder pin enable connects the reference level to its output pin.
// - range set gives zero-based source/24 steps, clear quarter-offset /32.
// - source select picks external reference pins when set, else supply rails.
// - 4-bit tap value selects one of sixteen ladder taps.
// - each control register has clear, set, invert aliases at +4, +8, +c.
package cmp_pkg;
  localparam int unsigned NUM_CMP = 3;
  localparam logic [15:0] ADDR_CMP1 = 16'ha000;
  localparam logic [15:0] ADDR_CMP2 = 16'ha010;
  localparam logic [15:0] ADDR_CMP3 = 16'ha020;
  localparam logic [15:0] ADDR_STAT = 16'ha060;
  localparam logic [15:0] ADDR_LADDER = 16'h9800;
  localparam logic [15:0] ADDR_IRQ_FLAG = 16'ha070;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'ha080;
  localparam logic [1:0] ALIAS_PLAIN = 2'h0;
  localparam logic [1:0] ALIAS_CLR = 2'h1;
  localparam logic [1:0] ALIAS_SET = 2'h2;
  localparam logic [1:0] ALIAS_INV = 2'h3;
  // comparator control fields
  localparam int unsigned CC_ENABLE = 15;
  localparam int unsigned CC_PIN_EN = 14;
  localparam int unsigned CC_INVERT = 13;
  localparam int unsigned CC_RESULT = 8;
  localparam int unsigned CC_EDGE_LO = 6;
  localparam int unsigned CC_PLUS = 4;
  localparam int unsigned CC_MINUS_LO = 0;
  localparam logic [31:0] CC_WMASK = 32'h0000e0d3;
  localparam logic [31:0] CC_RESET = 32'h0000e0c3;
  // status fields
  localparam int unsigned ST_IDLE_HALT = 13;
  localparam logic [31:0] ST_WMASK = 32'h00002000;
  localparam logic [31:0] ST_RESET = 32'h00000000;
  // ladder fields
  localparam int unsigned LD_ENABLE = 15;
  localparam int unsigned LD_PIN_EN = 6;
  localparam int unsigned LD_RANGE = 5;
  localparam int unsigned LD_SOURCE = 4;
  localparam int unsigned LD_TAP_LO = 0;
  localparam logic [31:0] LD_WMASK = 32'h0000807f;
  localparam logic [31:0] LD_RESET = 32'h00000000;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

/* File: cmp_ctrl.sv */
// comparator bank control, status, ladder and interrupt logic
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
module analog_comparator_control (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [15:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // device power state
  input wire logic i_idle,
  // raw analog comparator results, asynchronous
  input wire logic [cmp_pkg::NUM_CMP-1:0] i_raw_result,
  // comparator analog controls
  output logic [cmp_pkg::NUM_CMP-1:0] o_cmp_power,
  output logic [cmp_pkg::NUM_CMP-1:0] o_plus_input_select,
  output logic [2*cmp_pkg::NUM_CMP-1:0] o_minus_input_select,
  // result pins
  output logic [cmp_pkg::NUM_CMP-1:0] o_result_pin,
  output logic [cmp_pkg::NUM_CMP-1:0] o_result_pin_oe,
  // ladder controls
  output logic o_ladder_power,
  output logic o_ladder_pin_enable,
  output logic o_ladder_range_select,
  output logic o_ladder_source_select,
  output logic [3:0] o_ladder_tap_value,
  // interrupt
  output logic o_irq
);
  import cmp_pkg::*;

  typedef struct packed {
    logic [NUM_CMP-1:0][31:0] ctrl;
    logic [31:0] stat;
    logic [31:0] ladder;
    logic [NUM_CMP-1:0] sync1;
    logic [NUM_CMP-1:0] sync2;
    logic [NUM_CMP-1:0] prev;
    logic [NUM_CMP-1:0] flag;
    logic [NUM_CMP-1:0] mask;
    logic [NUM_CMP-1:0] pin;
    logic [31:0] rdata;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic [NUM_CMP-1:0] running;
  logic [NUM_CMP-1:0] result;
  logic [NUM_CMP-1:0] rise;
  logic [NUM_CMP-1:0] fall;
  logic [NUM_CMP-1:0] event_hit;
  logic [15:0] base;
  logic [1:0] alias_sel;

  assign base = {i_addr[15:4], 4'h0};
  assign alias_sel = i_addr[3:2];

  // alias write: plain, clear, set or toggle, limited to writable bits
  function automatic logic [31:0] apply_write(input logic [31:0] cur,
      input logic [31:0] wd, input logic [1:0] sel,
      input logic [31:0] wmask);
    logic [31:0] v;
    v = cur;
    case (sel)
      ALIAS_PLAIN: v = wd;
      ALIAS_CLR: v = cur & ~wd;
      ALIAS_SET: v = cur | wd;
      ALIAS_INV: v = cur ^ wd;
      default: v = cur;
    endcase
    return (v & wmask) | (cur & ~wmask);
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_CMP; g++) begin : g_cmp
      // halted in idle only when idle halt is set
      assign running[g] = st_r.ctrl[g][CC_ENABLE] &
        ~(i_idle & st_r.stat[ST_IDLE_HALT]);
      // synchronised result, inverted when asked; a stopped one reads zero
      assign result[g] = running[g] &
        (st_r.sync2[g] ^ st_r.ctrl[g][CC_INVERT]);
      assign rise[g] = result[g] & ~st_r.prev[g];
      assign fall[g] = ~result[g] & st_r.prev[g];
      always_comb begin
        case (st_r.ctrl[g][CC_EDGE_LO+:2])
          EDGE_RISE: event_hit[g] = rise[g];
          EDGE_FALL: event_hit[g] = fall[g];
          EDGE_BOTH: event_hit[g] = rise[g] | fall[g];
          default: event_hit[g] = 1'b0;
        endcase
      end
      assign o_cmp_power[g] = running[g];
      assign o_plus_input_select[g] = st_r.ctrl[g][CC_PLUS];
      assign o_minus_input_select[2*g+:2] =
        st_r.ctrl[g][CC_MINUS_LO+:2];
      assign o_result_pin[g] = st_r.pin[g];
      assign o_result_pin_oe[g] = st_r.ctrl[g][CC_PIN_EN];
    end
  endgenerate

  always_comb begin
    logic [31:0] rd;
    logic [NUM_CMP-1:0] clr_flag;
    rd = 32'h0;
    clr_flag = '0;
    st_nxt = st_r;
    st_nxt.sync1 = i_raw_result;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = result;
    st_nxt.pin = result;
    for (int i = 0; i < NUM_CMP; i++) begin
      st_nxt.ctrl[i][CC_RESULT] = result[i];
      st_nxt.stat[i] = result[i];
    end
    // reads
    if (i_rd) begin
      case (i_addr)
        ADDR_CMP1: rd = st_r.ctrl[0];
        ADDR_CMP2: rd = st_r.ctrl[1];
        ADDR_CMP3: rd = st_r.ctrl[2];
        ADDR_STAT: rd = st_r.stat;
        ADDR_LADDER: rd = st_r.ladder;
        ADDR_IRQ_FLAG: begin
          rd = {29'h0, st_r.flag};
          clr_flag = st_r.flag;
        end
        ADDR_IRQ_MASK: rd = {29'h0, st_r.mask};
        default: rd = 32'h0;
      endcase
    end
    st_nxt.rdata = rd;
    // writes; a clear, set or toggle of the enable bit leaves the other fields as they were
    if (i_wr) begin
      case (base)
        ADDR_CMP1: st_nxt.ctrl[0] = apply_write(st_r.ctrl[0], i_wdata,
          alias_sel, CC_WMASK);
        ADDR_CMP2: st_nxt.ctrl[1] = apply_write(st_r.ctrl[1], i_wdata,
          alias_sel, CC_WMASK);
        ADDR_CMP3: st_nxt.ctrl[2] = apply_write(st_r.ctrl[2], i_wdata,
          alias_sel, CC_WMASK);
        ADDR_STAT: st_nxt.stat = apply_write(st_r.stat, i_wdata,
          alias_sel, ST_WMASK);
        ADDR_LADDER: st_nxt.ladder = apply_write(st_r.ladder, i_wdata,
          alias_sel, LD_WMASK);
        // the mask has no alias words; only its own address writes it
        ADDR_IRQ_MASK: begin
          if (alias_sel == ALIAS_PLAIN) begin
            st_nxt.mask = i_wdata[NUM_CMP-1:0];
          end
        end
        default: ;
      endcase
      for (int i = 0; i < NUM_CMP; i++) begin
        st_nxt.ctrl[i][CC_RESULT] = result[i];
        st_nxt.stat[i] = result[i];
      end
    end
    // a new event wins over a read-clear in the same cycle
    st_nxt.flag = (st_r.flag & ~clr_flag) | event_hit;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < NUM_CMP; i++) begin
        st_r.ctrl[i] <= CC_RESET;
      end
      st_r.stat <= ST_RESET;
      st_r.ladder <= LD_RESET;
      st_r.sync1 <= '0;
      st_r.sync2 <= '0;
      st_r.prev <= '0;
      st_r.flag <= '0;
      st_r.mask <= '0;
      st_r.pin <= '0;
      st_r.rdata <= 32'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata = st_r.rdata;
  assign o_irq = |(st_r.flag & st_r.mask);
  assign o_ladder_power = st_r.ladder[LD_ENABLE];
  assign o_ladder_pin_enable = st_r.ladder[LD_PIN_EN];
  // range and source only steer the analog ladder switches
  assign o_ladder_range_select = st_r.ladder[LD_RANGE];
  assign o_ladder_source_select = st_r.ladder[LD_SOURCE];
  assign o_ladder_tap_value = st_r.ladder[LD_TAP_LO+:4];
endmodule // analog_comparator_control

/* File: cmp_ctrl_checker_assertions.sv */
// port-level assertions for the comparator control block
`timescale 1ns/10ps
module cmp_ctrl_checker
  import cmp_pkg::*;
(
  // clock, reset, register port, idle
  input wire logic i_clk, i_rst, i_wr, i_rd, i_idle,
  input wire logic [15:0] i_addr,
  input wire logic [31:0] i_wdata, o_rdata,
  // comparator side
  input wire logic [2:0] i_raw_result, o_cmp_power, o_plus_input_select,
  input wire logic [2:0] o_result_pin, o_result_pin_oe,
  input wire logic [5:0] o_minus_input_select,
  // ladder and interrupt
  input wire logic o_ladder_power, o_ladder_pin_enable, o_irq,
  input wire logic o_ladder_range_select, o_ladder_source_select,
  input wire logic [3:0] o_ladder_tap_value
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire w_ld = i_wr && i_addr == ADDR_LADDER;
  wire w_clr1 = i_wr && i_addr == ADDR_CMP1 + 16'h4;
  chk_rdata_quiet: assert property (
    !$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  chk_ladder_tap: assert property ($past(w_ld) |->
    o_ladder_tap_value == $past(i_wdata[3:0])
    && o_ladder_source_select == $past(i_wdata[4]))
    else $error("ladder tap or source not taken from write");
  chk_ladder_range: assert property ($past(w_ld) |->
    o_ladder_range_select == $past(i_wdata[5])) else $error("range wrong");
  chk_ladder_pin: assert property ($past(w_ld) |->
    o_ladder_pin_enable == $past(i_wdata[6])) else $error("pin en wrong");
  chk_ladder_power: assert property ($past(w_ld) |->
    o_ladder_power == $past(i_wdata[15])) else $error("ladder power wrong");
  chk_pin_set: assert property (
    i_wr && i_addr == ADDR_CMP1 + 16'h8
    && i_wdata[14] |=> o_result_pin_oe[0]) else $error("set alias missed");
  chk_enable_clr: assert property (w_clr1 && i_wdata == 32'h8000 |=>
    !o_cmp_power[0] && $stable(o_result_pin_oe)
    && $stable(o_minus_input_select)) else $error("enable clear disturbed");
  chk_minus_sel: assert property (
    i_wr && i_addr == ADDR_CMP2 |=>
    o_minus_input_select[3:2] == $past(i_wdata[1:0])
    && o_plus_input_select[1] == $past(i_wdata[4])) else $error("input sel");
  chk_stat_zero: assert property (
    $past(i_rd && i_addr == ADDR_STAT) |->
    (o_rdata & ~32'h00002007) == 32'h0) else $error("status reserved set");
  chk_idle_stop: assert property (i_wr && i_addr == ADDR_STAT
    && i_wdata[13] ##1 i_idle [*2] |-> o_cmp_power == 3'h0)
    else $error("comparators run in idle with halt set");
endmodule // cmp_ctrl_checker
bind analog_comparator_control cmp_ctrl_checker i_chk (.*);

/* File: cmp_analog_model.sv */
// behavioural comparator bank driving raw results
`timescale 1ns/10ps
module cmp_analog_model (
  // commanded outcomes
  input wire logic [2:0] i_level,
  // raw results toward the block
  output logic [2:0] o_raw
);
  initial o_raw = 3'h0;
  // off-grid delay keeps edges unrelated to the sampling clock
  always @(i_level) o_raw <= #2.7 i_level;
endmodule // cmp_analog_model

/* File: analog_comparator_control_tb.sv */
// self-checking bench for the comparator control block
`timescale 1ns/10ps
module analog_comparator_control_tb;
  import cmp_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_idle = 1'b0;
  logic [15:0] i_addr = 16'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic [2:0] lvl = 3'h0, i_raw_result, o_cmp_power, o_plus_input_select;
  logic [2:0] o_result_pin, o_result_pin_oe;
  logic [5:0] o_minus_input_select;
  logic [3:0] o_ladder_tap_value;
  logic o_ladder_power, o_ladder_pin_enable, o_ladder_range_select;
  logic o_ladder_source_select, o_irq, e_r, e_f;
  int fail_count = 0, samples_checked = 0;
  always #4 i_clk = ~i_clk;
  analog_comparator_control i_dut (.*);
  cmp_analog_model i_model (.i_level(lvl), .o_raw(i_raw_result));
  task automatic chk(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge i_clk);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clk);
    i_wr <= 1'b0;
    // let the edge that takes the write settle before anyone samples
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e, m);
    @(posedge i_clk);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk("rdata", e, o_rdata & m);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    rd(ADDR_CMP1, 32'h0000e1c3, '1);
    rd(ADDR_STAT, 32'h7, '1);
    rd(ADDR_LADDER, 32'h0, '1);
    rd(16'h1234, 32'h0, '1);
    rd(ADDR_IRQ_FLAG + 16'h4, 32'h0, '1);
    wr(ADDR_LADDER, 32'hffffffff);
    rd(ADDR_LADDER, 32'h0000807f, '1);
    chk("tap", 32'hf, 32'(o_ladder_tap_value));
    wr(ADDR_LADDER + 16'hc, 32'h8020);
    rd(ADDR_LADDER, 32'h0000005f, '1);
    chk("range", 32'h0, 32'(o_ladder_range_select));
    wr(ADDR_LADDER + 16'h4, 32'h0050);
    rd(ADDR_LADDER, 32'h0000000f, '1);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CMP2, 32'h8000 | 32'(m) | (32'(m & 1) << 4));
      chk("minus", 32'(m), 32'(o_minus_input_select[3:2]));
      chk("plus", 32'(m & 1), 32'(o_plus_input_select[1]));
    end
    wr(ADDR_CMP1 + 16'h4, 32'h2000);
    rd(ADDR_CMP1, 32'h0000c0c3, '1);
    lvl[0] <= 1'b1;
    repeat (6) @(posedge i_clk);
    rd(ADDR_STAT, 32'h5, '1);
    chk("pin", 32'h1, 32'(o_result_pin[0] & o_result_pin_oe[0]));
    wr(ADDR_CMP1 + 16'h4, 32'h8000);
    @(posedge i_clk);
    rd(ADDR_CMP1, 32'h000040c3, '1);
    wr(ADDR_CMP1 + 16'h8, 32'h8000);
    wr(ADDR_STAT, 32'h2000);
    i_idle <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk("power", 32'h0, 32'(o_cmp_power));
    rd(ADDR_STAT, 32'h2000, '1);
    i_idle <= 1'b0;
    wr(ADDR_STAT, 32'h0);
    chk("power", 32'h7, 32'(o_cmp_power));
    lvl[0] <= 1'b0;
    wr(ADDR_IRQ_MASK, 32'h1);
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_CMP1, 32'h8000 | (32'(k[2]) << 13) | (32'(k[1:0]) << 6));
      repeat (5) @(posedge i_clk);
      rd(ADDR_IRQ_FLAG, 32'h0, 32'h0);
      lvl[0] <= 1'b1;
      e_r = k[2] ? k[1] : k[0];
      e_f = k[2] ? k[0] : k[1];
      repeat (6) @(posedge i_clk);
      chk("irq", 32'(e_r), 32'(o_irq));
      rd(ADDR_IRQ_FLAG, 32'(e_r), 32'h1);
      lvl[0] <= 1'b0;
      repeat (6) @(posedge i_clk);
      rd(ADDR_IRQ_FLAG, 32'(e_f), 32'h1);
    end
    wr(ADDR_IRQ_MASK, 32'h0);
    lvl[0] <= 1'b1;
    repeat (6) @(posedge i_clk);
    chk("masked irq", 32'h0, 32'(o_irq));
    rd(ADDR_IRQ_FLAG, 32'h1, 32'h1);
    give_verdict();
  end
  initial begin
    #100us;
    fail_count++;
    give_verdict();
  end
endmodule // analog_comparator_control_tb
